/* hdl/lcdks_pkg.sv */
// constants and carrier types for the segment / key-scan pin output block
// assumes a single 20 MHz core clock; no software-visible registers
//
// Functional notes
// - power-on reset or clock stop: every shared pin is a segment pin driven low
// - power-on reset or clock stop: both backplanes held statically low
// - CE reset or halt: segment pins keep waveform, port pins hold their value
// - CE reset or halt: both backplanes keep their normal common waveform
// - key-scan data goes out in slots interleaved with segment frames, 64 keys
// - scan drive only with port select clear, display on and scan enable set
// - display off: segment pins stay low and no scan drive appears
// - in the scan slot each scan pin follows its scan drive register bit
// - key returns are sampled only at scan slot timing
package lcdks_pkg;
   localparam int CLK_MHZ = 20;
   localparam int PHASE_TIME_US = 1000;
   localparam int PHASE_CYC = PHASE_TIME_US * CLK_MHZ;
   localparam int SCAN_TIME_US = 100;
   localparam int SCAN_CYC = SCAN_TIME_US * CLK_MHZ;
   localparam int CNT_W = 16;
   localparam int SEG_PINS = 30;
   localparam int SCAN_PINS = 16;
   localparam int UPPER_PINS = SEG_PINS - SCAN_PINS;
   localparam int RET_PINS = 4;
   localparam logic [1:0] LVL_LOW = 2'h0;
   localparam logic [1:0] LVL_HALF = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   typedef enum logic [2:0] {PH_0, PH_1, PH_2, PH_3, PH_SCAN} lcdks_phase_e;

   typedef struct packed {
      logic valid;
      logic [RET_PINS-1:0] data;
   } lcdks_key_s;
endpackage

/* hdl/lcdks_sync.sv */
// two-flop synchroniser for levels entering the core clock domain
// assumes async active-low reset; first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module lcdks_sync #(
   parameter int W = 1
) (
   input wire logic i_clk, // core clock
   input wire logic i_rst_b, // async reset, active low
   input wire logic [W-1:0] i_d, // asynchronous level in
   output logic [W-1:0] o_q // synchronised level out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_ff <= '0;
         o_q <= '0;
      end else begin
         meta_ff <= i_d;
         o_q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

/* hdl/lcdks_top.sv */
// segment / backplane pin control with time-shared key-scan drive
// assumes control flags and dot data come from core-clock logic;
// key returns are asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module lcdks_top
   import lcdks_pkg::*;
#(
   parameter int PHASE_CYC_P = PHASE_CYC,
   parameter int SCAN_CYC_P = SCAN_CYC
) (
   input wire logic I_CORE_CLK, // 20 MHz core clock
   input wire logic I_RST_B, // power-on reset, active low
   input wire logic I_CLOCK_STOP, // clock-stop condition, level
   input wire logic I_CE_RESET, // CE reset active, level
   input wire logic I_HALT, // halt active, level
   input wire logic I_DISPLAY_ON_FLAG, // display on
   input wire logic I_SCAN_DRIVE_ENABLE_FLAG, // key-scan enable
   input wire logic I_LOW_BANK_PORT_SELECT_FLAG, // low 16 pins as port
   input wire logic [SCAN_PINS-1:0] I_SCAN_DRIVE_REGISTER, // scan / port data
   input wire logic [UPPER_PINS-1:0] I_UPPER_PORT_SELECT, // upper pins as port
   input wire logic [UPPER_PINS-1:0] I_UPPER_PORT_DATA, // upper port data
   input wire logic [SEG_PINS-1:0] I_DOT_A, // dots on backplane 1
   input wire logic [SEG_PINS-1:0] I_DOT_B, // dots on backplane 0
   input wire logic [RET_PINS-1:0] I_KEY_RETURN_INPUTS, // key return pins
   output logic [SEG_PINS-1:0] O_SEG_PIN, // segment / scan / port pins
   output logic [1:0] O_BACKPLANE_0, // backplane 0 level code
   output logic [1:0] O_BACKPLANE_1, // backplane 1 level code
   output logic O_SCAN_SLOT, // scan drive active
   output lcdks_key_s O_KEY // captured key returns
);
   logic rst_b;
   logic [RET_PINS-1:0] ret_sync;
   lcdks_phase_e phase_ff;
   lcdks_phase_e nxt_phase;
   logic [CNT_W-1:0] cnt_ff;
   logic tick;
   logic scan_ok;
   logic freeze;
   logic [SEG_PINS-1:0] port_mask;
   logic [SEG_PINS-1:0] port_data;
   logic [SEG_PINS-1:0] seg_wave;
   logic [SEG_PINS-1:0] nxt_seg;
   logic [1:0] nxt_bp0;
   logic [1:0] nxt_bp1;

   lcdks_sync #(.W(1)) u_rst_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_b(I_RST_B),
      .i_d(1'b1),
      .o_q(rst_b)
   );

   lcdks_sync #(.W(RET_PINS)) u_ret_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_b(rst_b),
      .i_d(I_KEY_RETURN_INPUTS),
      .o_q(ret_sync)
   );

   assign scan_ok = !I_LOW_BANK_PORT_SELECT_FLAG && I_DISPLAY_ON_FLAG &&
                    I_SCAN_DRIVE_ENABLE_FLAG;
   assign freeze = I_CE_RESET || I_HALT;
   assign port_mask = {I_UPPER_PORT_SELECT, {SCAN_PINS{I_LOW_BANK_PORT_SELECT_FLAG}}};
   assign port_data = {I_UPPER_PORT_DATA, I_SCAN_DRIVE_REGISTER};

   // phase timer; scan slot is shorter than a common phase
   always_comb begin
      if (phase_ff == PH_SCAN) begin
         tick = (cnt_ff == CNT_W'(SCAN_CYC_P - 1));
      end else begin
         tick = (cnt_ff == CNT_W'(PHASE_CYC_P - 1));
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= '0;
      end else if (I_CLOCK_STOP || tick) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end

   // four common phases, then a scan slot when scan drive is allowed
   always_comb begin
      case (phase_ff)
         PH_0: nxt_phase = PH_1;
         PH_1: nxt_phase = PH_2;
         PH_2: nxt_phase = PH_3;
         PH_3: nxt_phase = scan_ok ? PH_SCAN : PH_0;
         PH_SCAN: nxt_phase = PH_0;
         default: nxt_phase = PH_0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff <= PH_0;
      end else if (I_CLOCK_STOP) begin
         phase_ff <= PH_0;
      end else if (tick) begin
         phase_ff <= nxt_phase;
      end
   end

   // segment low against a driven-high common lights the dot, and vice versa
   always_comb begin
      case (phase_ff)
         PH_0: seg_wave = ~I_DOT_B;
         PH_1: seg_wave = ~I_DOT_A;
         PH_2: seg_wave = I_DOT_B;
         PH_3: seg_wave = I_DOT_A;
         default: seg_wave = '0;
      endcase
   end

   // pin priority: stop, port, display off, scan slot, segment waveform
   always_comb begin
      for (int i = 0; i < SEG_PINS; i++) begin
         if (I_CLOCK_STOP) begin
            nxt_seg[i] = 1'b0;
         end else if (port_mask[i]) begin
            nxt_seg[i] = freeze ? O_SEG_PIN[i] : port_data[i];
         end else if (!I_DISPLAY_ON_FLAG) begin
            nxt_seg[i] = 1'b0;
         end else if (phase_ff == PH_SCAN) begin
            nxt_seg[i] = (i < SCAN_PINS) && scan_ok && port_data[i];
         end else begin
            nxt_seg[i] = seg_wave[i];
         end
      end
   end

   // commons run through CE reset and halt; quarter-period phase offset
   always_comb begin
      nxt_bp0 = LVL_HALF;
      nxt_bp1 = LVL_HALF;
      if (I_CLOCK_STOP) begin
         nxt_bp0 = LVL_LOW;
         nxt_bp1 = LVL_LOW;
      end else begin
         case (phase_ff)
            PH_0: nxt_bp0 = LVL_HIGH;
            PH_1: nxt_bp1 = LVL_HIGH;
            PH_2: nxt_bp0 = LVL_LOW;
            PH_3: nxt_bp1 = LVL_LOW;
            default: nxt_bp0 = LVL_HALF;
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         O_SEG_PIN <= '0;
      end else begin
         O_SEG_PIN <= nxt_seg;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         O_BACKPLANE_0 <= LVL_LOW;
         O_BACKPLANE_1 <= LVL_LOW;
      end else begin
         O_BACKPLANE_0 <= nxt_bp0;
         O_BACKPLANE_1 <= nxt_bp1;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         O_SCAN_SLOT <= 1'b0;
      end else begin
         O_SCAN_SLOT <= !I_CLOCK_STOP && phase_ff == PH_SCAN && scan_ok;
      end
   end

   // sample at slot end so return lines have settled through the sync
   always_ff @(posedge I_CORE_CLK or negedge rst_b) begin
      if (!rst_b) begin
         O_KEY <= '0;
      end else begin
         O_KEY.valid <= !I_CLOCK_STOP && tick && phase_ff == PH_SCAN && scan_ok;
         if (!I_CLOCK_STOP && tick && phase_ff == PH_SCAN && scan_ok) begin
            O_KEY.data <= ret_sync;
         end
      end
   end

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!rst_b);

   AST_STOP_PINS_LOW: assert property (I_CLOCK_STOP |=> O_SEG_PIN == '0)
      else $error("pins not low after clock stop");

   AST_STOP_BP_LOW: assert property (I_CLOCK_STOP |=>
      O_BACKPLANE_0 == LVL_LOW && O_BACKPLANE_1 == LVL_LOW)
      else $error("backplanes not low in clock stop");

   AST_FREEZE_PORT_HOLD: assert property (freeze && !I_CLOCK_STOP |=>
      ((O_SEG_PIN ^ $past(O_SEG_PIN)) & $past(port_mask)) == '0)
      else $error("port pin changed during ce reset or halt");

   AST_FREEZE_COM_RUN: assert property (freeze && !I_CLOCK_STOP && phase_ff == PH_1 |=>
      O_BACKPLANE_1 == LVL_HIGH && O_BACKPLANE_0 == LVL_HALF)
      else $error("common waveform stopped during ce reset or halt");

   AST_SCAN_AFTER_FRAME: assert property (!I_CLOCK_STOP && phase_ff == PH_3 && tick &&
      scan_ok |=> phase_ff == PH_SCAN ##1 (!I_CLOCK_STOP && scan_ok) [*2] ##0 O_SCAN_SLOT)
      else $error("scan slot missing after frame");

   AST_SCAN_GATED: assert property (O_SCAN_SLOT |-> $past(scan_ok))
      else $error("scan drive without enables");

   AST_DISPLAY_OFF: assert property (!I_DISPLAY_ON_FLAG && !I_CLOCK_STOP |=>
      (O_SEG_PIN & ~$past(port_mask)) == '0 && !O_SCAN_SLOT)
      else $error("segment or scan output with display off");

   AST_SCAN_DATA: assert property (O_SCAN_SLOT |->
      O_SEG_PIN[SCAN_PINS-1:0] == $past(I_SCAN_DRIVE_REGISTER))
      else $error("scan pins differ from scan drive register");

   AST_KEY_IN_SLOT: assert property (O_KEY.valid |->
      $past(phase_ff) == PH_SCAN && O_KEY.data == $past(ret_sync))
      else $error("key capture outside scan slot");

   AST_DOT_A_PHASE: assert property (phase_ff == PH_1 && I_DISPLAY_ON_FLAG &&
      !I_CLOCK_STOP && !port_mask[0] |=> O_SEG_PIN[0] == !$past(I_DOT_A[0]))
      else $error("dot a not driven against backplane 1");
endmodule
`default_nettype wire

/* testbench/lcdks_key_matrix.sv */
// passive key switch matrix model across the sixteen scan pins
// assumes return lines pulled low where no closed key meets a high pin
`timescale 1ns/10ps
`default_nettype none
module lcdks_key_matrix (
   input wire logic [15:0] i_scan, // scan pin levels
   input wire logic [63:0] i_pressed, // closed keys, bit 4*pin+return
   output logic [3:0] o_ret // key return levels
);
   always_comb begin
      o_ret = 4'h0;
      for (int i = 0; i < 16; i++) begin
         o_ret = o_ret | (i_scan[i] ? i_pressed[4*i +: 4] : 4'h0);
      end
   end
endmodule
`default_nettype wire

/* testbench/lcdks_tb_top.sv */
// self-checking bench for the segment / key-scan pin block
// assumes shortened phase and slot counts; matrix model on pins 0..15
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module lcdks_tb_top;
   import lcdks_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic stop = 1'b0, ce = 1'b0, halt = 1'b0, disp = 1'b0, scan_drive_enable_flag = 1'b0, psel = 1'b0;
   logic [15:0] scan_drive_register = 16'h0;
   logic [13:0] usel = 14'h0, udat = 14'h0;
   logic [29:0] dot_a = 30'h0, dot_b = 30'h0, seg, hv;
   logic [63:0] pressed = 64'h0;
   logic [3:0] ret;
   logic [1:0] bp0, bp1;
   logic slot;
   lcdks_key_s key;
   int errors = 0, cmp_count = 0, cyc = 0, nslot = 0;
   always #25 clk = ~clk;
   lcdks_top #(.PHASE_CYC_P(8), .SCAN_CYC_P(6)) i_lcdks_top (.I_CORE_CLK(clk),
      .I_RST_B(rst_b), .I_CLOCK_STOP(stop), .I_CE_RESET(ce), .I_HALT(halt),
      .I_DISPLAY_ON_FLAG(disp), .I_SCAN_DRIVE_ENABLE_FLAG(scan_drive_enable_flag),
      .I_LOW_BANK_PORT_SELECT_FLAG(psel), .I_SCAN_DRIVE_REGISTER(scan_drive_register),
      .I_UPPER_PORT_SELECT(usel), .I_UPPER_PORT_DATA(udat), .I_DOT_A(dot_a),
      .I_DOT_B(dot_b), .I_KEY_RETURN_INPUTS(ret), .O_SEG_PIN(seg),
      .O_BACKPLANE_0(bp0), .O_BACKPLANE_1(bp1), .O_SCAN_SLOT(slot), .O_KEY(key));
   lcdks_key_matrix i_lcdks_key_matrix (.i_scan(seg[15:0]), .i_pressed(pressed),
      .o_ret(ret));
   function automatic logic [29:0] exp_seg(input logic [1:0] b0, input logic [1:0] b1);
      logic [29:0] s;
      s = 30'h0;
      if (b0 == LVL_HIGH && b1 == LVL_HALF) s = ~dot_b;
      if (b0 == LVL_HALF && b1 == LVL_HIGH) s = ~dot_a;
      if (b0 == LVL_LOW && b1 == LVL_HALF) s = dot_b;
      if (b0 == LVL_HALF && b1 == LVL_LOW) s = dot_a;
      if (!disp) s = 30'h0;
      return s;
   endfunction
   function automatic logic [3:0] exp_key(input logic [15:0] k);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 16; i++) r = r | (k[i] ? pressed[4*i +: 4] : 4'h0);
      return r;
   endfunction
   // settle two cycles first: inputs land one edge later
   task automatic watch(input int n, input logic [29:0] pv);
      logic [3:0] seen;
      logic [29:0] m;
      seen = 4'h0;
      nslot = 0;
      m = {usel, {16{psel}}};
      repeat (2) @(negedge clk);
      repeat (n) begin
         @(negedge clk);
         if (slot) nslot++;
         else begin
            `CHK(seg, (exp_seg(bp0, bp1) & ~m) | (pv & m))
            seen = seen | {bp1 == LVL_LOW, bp0 == LVL_LOW, bp1 == LVL_HIGH, bp0 == LVL_HIGH};
         end
      end
      `CHK(seen, 4'hf)
   endtask
   task automatic scan_once;
      int t;
      t = 0;
      // previous slot still stands one cycle after its key capture
      while (slot === 1'b1) begin
         @(negedge clk);
      end
      while (slot !== 1'b1 && t < 100) begin
         @(negedge clk);
         t++;
      end
      `CHK(seg[15:0], scan_drive_register)
      `CHK(seg[29:16], 14'h0)
      `CHK({bp0, bp1}, {LVL_HALF, LVL_HALF})
      t = 0;
      while (key.valid !== 1'b1 && t < 40) begin
         @(negedge clk);
         t++;
      end
      `CHK(key.valid, 1'b1)
      `CHK(key.data, exp_key(scan_drive_register))
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'hd11a));
      repeat (12) @(negedge clk);
      `CHK(seg, 30'h0)
      `CHK({bp0, bp1}, 4'h0)
      rst_b = 1'b1;
      dot_a = 30'($urandom);
      dot_b = 30'($urandom);
      disp = 1'b1;
      watch(80, 30'h0);
      $display("test waveform done");
      scan_drive_enable_flag = 1'b1;
      for (int k = 0; k < 4; k++) begin
         scan_drive_register = (k == 0) ? 16'hffff : (k == 1) ? 16'h0001 : 16'($urandom);
         pressed = {$urandom, $urandom};
         scan_once();
      end
      $display("test scan done");
      // port select, display off, scan off: each must suppress the slot
      for (int k = 0; k < 3; k++) begin
         {psel, disp, scan_drive_enable_flag} = (k == 0) ? 3'b111 : (k == 1) ? 3'b001 : 3'b010;
         watch(80, {udat, scan_drive_register});
         `CHK(nslot, 0)
      end
      $display("test refusal done");
      usel = 14'($urandom);
      stop = 1'b1;
      repeat (3) @(negedge clk);
      repeat (4) begin
         @(negedge clk);
         `CHK({seg, bp0, bp1}, 34'h0)
      end
      stop = 1'b0;
      $display("test clock stop done");
      for (int k = 0; k < 2; k++) begin
         udat = 14'($urandom);
         scan_drive_register = 16'($urandom);
         watch(40, {udat, scan_drive_register});
         hv = {udat, scan_drive_register};
         ce = (k == 0);
         halt = (k == 1);
         udat = ~udat;
         scan_drive_register = ~scan_drive_register;
         watch(80, hv);
         ce = 1'b0;
         halt = 1'b0;
         watch(40, {udat, scan_drive_register});
      end
      $display("test ce reset and halt done");
      final_report();
   end
endmodule
`default_nettype wire
